// >>> hdl/rgw_regs.vh
// Constants of the gap write decoder: register offsets, field positions,
// reset values, interval windows and frame codes.
// Assumes inclusion by bare name from the design files.
`ifndef RGW_REGS_VH
`define RGW_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RGW_OFS_CTRL      4'h0
`define RGW_OFS_PASSWORD  4'h1
`define RGW_OFS_STATUS    4'h2
`define RGW_OFS_MASK      4'h3
`define RGW_OFS_PROG_DATA 4'h4
`define RGW_OFS_PROG_INFO 4'h5

// ----------------------------------------------------------------------
// Control field positions and reset values
// ----------------------------------------------------------------------
`define RGW_CTRL_WAKE_BIT  0
`define RGW_CTRL_MOD_LSB   1
`define RGW_CTRL_RATE_LSB  4
`define RGW_CTRL_BLK_LSB   7
`define RGW_MOD_BIN        3'h0
`define RGW_MOD_FSK        3'h1
`define RGW_MOD_PSK        3'h2
`define RGW_MOD_MANCHESTER 3'h3
`define RGW_MOD_BIPHASE    3'h4
`define RGW_RST_WAKE       1'h0
`define RGW_RST_MOD        3'h3
`define RGW_RST_RATE       3'h2
`define RGW_RST_BLK        3'h2
`define RGW_RST_PASSWORD   32'h0000_0000

// ----------------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------------
`define RGW_ST_PROG  0
`define RGW_ST_WAKE  1
`define RGW_ST_STOP  2
`define RGW_ST_ERR   3

// ----------------------------------------------------------------------
// Interval windows in counted field clocks, and frame layout
// ----------------------------------------------------------------------
`define RGW_ZERO_MIN 7'h10
`define RGW_ZERO_MAX 7'h20
`define RGW_ONE_MIN  7'h30
`define RGW_ONE_MAX  7'h40
`define RGW_OP_WRITE 2'h2
`define RGW_OP_WAKE  2'h1
`define RGW_OP_STOP  2'h3
`define RGW_LEN_WRITE 6'h26
`define RGW_LEN_WAKE  6'h22
`define RGW_LEN_STOP  6'h02

`endif

// >>> hdl/rgw_pin_sync.v
// Pin synchroniser: three flip-flops, a change counts when the last two agree.
// Assumes the pin is asynchronous to mclk and slow against it.
`timescale 1ns/1ps

module rgw_pin_sync (
  input  wire mclk,
  input  wire rst,
  input  wire pin_in,
  output wire level,
  output wire rise
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg level_reg;
  reg rise_reg;

  always @(posedge mclk) begin
    if (rst) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_reg <= 1'b0;
      rise_reg  <= 1'b0;
    end else begin
      s1_reg   <= pin_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      rise_reg <= 1'b0;
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
        rise_reg  <= s3_reg & ~level_reg;
      end
    end
  end

  assign level = level_reg;
  assign rise  = rise_reg;

endmodule // rgw_pin_sync

// >>> hdl/rgw_interval_count.v
// Interval counter: counts field clocks between detected gaps and classifies.
// Assumes one-cycle pulses for field clock rise and gap start on mclk.
`timescale 1ns/1ps
`include "rgw_regs.vh"

module rgw_interval_count #(
  parameter CW = 7
) (
  input  wire mclk,
  input  wire rst,
  input  wire field_rise,
  input  wire gap_start,
  output wire bit_stb,
  output wire bit_val,
  output wire bit_err,
  output wire timeout
);

  reg  [CW-1:0] count_reg;
  reg           stb_reg;
  reg           val_reg;
  reg           err_reg;
  reg           tmo_reg;
  wire          is_zero;
  wire          is_one;

  assign is_zero = (count_reg >= `RGW_ZERO_MIN) && (count_reg <= `RGW_ZERO_MAX);
  assign is_one  = (count_reg >= `RGW_ONE_MIN) && (count_reg <= `RGW_ONE_MAX);

  always @(posedge mclk) begin
    if (rst) begin
      count_reg <= {CW{1'b0}};
      stb_reg   <= 1'b0;
      val_reg   <= 1'b0;
      err_reg   <= 1'b0;
      tmo_reg   <= 1'b0;
    end else begin
      stb_reg <= 1'b0;
      err_reg <= 1'b0;
      tmo_reg <= 1'b0;
      if (gap_start) begin
        count_reg <= {CW{1'b0}};
        stb_reg   <= is_zero | is_one;
        err_reg   <= ~(is_zero | is_one);
        val_reg   <= is_one;
      end else if (field_rise && (count_reg != {CW{1'b1}})) begin
        count_reg <= count_reg + {{(CW-1){1'b0}}, 1'b1};
        tmo_reg   <= (count_reg == `RGW_ONE_MAX);
      end
    end
  end

  assign bit_stb = stb_reg;
  assign bit_val = val_reg;
  assign bit_err = err_reg;
  assign timeout = tmo_reg;

endmodule // rgw_interval_count

// >>> hdl/rgw_gap_decoder.v
// Gap write decoder with request wake and stop handling, plus registers.
// Assumes field clock and coil-low indication arrive as asynchronous pins.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "rgw_regs.vh"

module rgw_gap_decoder (
  input  wire        mclk,
  input  wire        rst,
  input  wire        field_clk_in,
  input  wire        coil_low_in,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [31:0] reg_rdata,
  output wire        irq,
  output wire        modulate_en,
  output wire        internal_reset,
  output wire        prog_stb,
  output wire        prog_lock,
  output wire [31:0] prog_data,
  output wire [2:0]  prog_block,
  output wire [2:0]  mod_type,
  output wire [7:0]  rate_div,
  output wire [2:0]  last_readout_block
);

  localparam ST_IDLE  = 2'b01;
  localparam ST_FRAME = 2'b10;

  // ----------------------------------------------------------------------
  // Divider decode
  // ----------------------------------------------------------------------
  function [7:0] rate_of;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    rate_of = 8'h08;
        3'h1:    rate_of = 8'h10;
        3'h2:    rate_of = 8'h20;
        3'h3:    rate_of = 8'h28;
        3'h4:    rate_of = 8'h32;
        3'h5:    rate_of = 8'h40;
        3'h6:    rate_of = 8'h64;
        default: rate_of = 8'h80;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Frame match decode
  // ----------------------------------------------------------------------
  // The operation code always leads the frame, so its position follows the
  // length of the command that is being matched.
  function frame_is;
    input [5:0]  len;
    input [37:0] bits;
    input [5:0]  want_len;
    input [1:0]  want_op;
    begin
      case (want_len)
        `RGW_LEN_WRITE: frame_is = (len == want_len) && (bits[37:36] == want_op);
        `RGW_LEN_WAKE:  frame_is = (len == want_len) && (bits[33:32] == want_op);
        default:        frame_is = (len == want_len) && (bits[1:0] == want_op);
      endcase
    end
  endfunction

  wire        field_rise;
  wire        gap_start;
  wire        bit_stb;
  wire        bit_val;
  wire        bit_err;
  wire        timeout;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg         first_reg;
  reg  [5:0]  nbits_reg;
  reg  [37:0] shift_reg;
  reg         awake_reg;
  reg         stopped_reg;
  reg         init_reg;
  reg         mod_out_reg;
  reg         ireset_reg;
  reg         pstb_reg;
  reg         plock_reg;
  reg  [31:0] pdata_reg;
  reg  [2:0]  pblock_reg;
  reg         ctrl_wake_reg;
  reg  [2:0]  ctrl_mod_reg;
  reg  [2:0]  ctrl_rate_reg;
  reg  [2:0]  ctrl_blk_reg;
  reg  [31:0] password_reg;
  reg  [3:0]  status_reg;
  reg  [3:0]  mask_reg;
  reg  [31:0] rdata_reg;

  reg         ev_prog;
  reg         ev_wake;
  reg         ev_stop;
  reg         ev_err;
  wire [3:0]  events;

  // ----------------------------------------------------------------------
  // Pin inputs and interval counting
  // ----------------------------------------------------------------------
  // Both pins pass the same three-stage filter, so their latency matches and a
  // gap is never seen ahead of the field clock that came before it.
  rgw_pin_sync u_field_sync (
    .mclk   (mclk),
    .rst    (rst),
    .pin_in (field_clk_in),
    .level  (),
    .rise   (field_rise)
  );

  rgw_pin_sync u_gap_sync (
    .mclk   (mclk),
    .rst    (rst),
    .pin_in (coil_low_in),
    .level  (),
    .rise   (gap_start)
  );

  rgw_interval_count #(
    .CW (7)
  ) u_count (
    .mclk       (mclk),
    .rst        (rst),
    .field_rise (field_rise),
    .gap_start  (gap_start),
    .bit_stb    (bit_stb),
    .bit_val    (bit_val),
    .bit_err    (bit_err),
    .timeout    (timeout)
  );

  // ----------------------------------------------------------------------
  // Frame state machine
  // ----------------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    ev_err     = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (gap_start) begin
          state_next = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (!first_reg && bit_err) begin
          state_next = ST_IDLE;
          ev_err     = 1'b1;
        end else if (!first_reg && bit_stb && (nbits_reg == `RGW_LEN_WRITE)) begin
          // A bit beyond the longest frame cannot belong to any command.
          state_next = ST_IDLE;
          ev_err     = 1'b1;
        end else if (timeout) begin
          // The field stayed on longer than any one, so the frame is complete.
          state_next = ST_IDLE;
          ev_err     = ~(ev_prog | ev_wake | ev_stop);
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Frame evaluation
  // ----------------------------------------------------------------------
  // Frame end evaluation happens on timeout, once the field stays on longer than a one.
  always @* begin
    ev_prog = 1'b0;
    ev_wake = 1'b0;
    ev_stop = 1'b0;
    if ((state_reg == ST_FRAME) && timeout && !first_reg) begin
      if (frame_is(nbits_reg, shift_reg, `RGW_LEN_WRITE, `RGW_OP_WRITE) && awake_reg) begin
        ev_prog = 1'b1;
      end
      // A stopped device listens for the wake command again, which is how the
      // reader brings it back after it has selected another transponder.
      // opcode plus password check
      if (frame_is(nbits_reg, shift_reg, `RGW_LEN_WAKE, `RGW_OP_WAKE)
          && (!awake_reg || stopped_reg) && (shift_reg[31:0] == password_reg)) begin
        ev_wake = 1'b1;
      end
      if (frame_is(nbits_reg, shift_reg, `RGW_LEN_STOP, `RGW_OP_STOP) && awake_reg) begin
        ev_stop = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Frame sequencing and link outputs
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      first_reg   <= 1'b0;
      nbits_reg   <= 6'h00;
      shift_reg   <= 38'h0;
      awake_reg   <= 1'b0;
      stopped_reg <= 1'b0;
      init_reg    <= 1'b1;
      ireset_reg  <= 1'b0;
      pstb_reg    <= 1'b0;
      plock_reg   <= 1'b0;
      pdata_reg   <= 32'h0000_0000;
      pblock_reg  <= 3'h0;
      mod_out_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      init_reg   <= 1'b0;
      ireset_reg <= 1'b0;
      pstb_reg   <= 1'b0;
      if (init_reg) begin
        awake_reg <= ~ctrl_wake_reg;
      end
      // The interval that ends at the start gap belongs to no frame, so the
      // first classification after the start gap is dropped.
      if ((state_reg == ST_IDLE) && gap_start) begin
        first_reg <= 1'b1;
        nbits_reg <= 6'h00;
      end else if ((state_reg == ST_FRAME) && (bit_stb || bit_err) && first_reg) begin
        first_reg <= 1'b0;
      end else if ((state_reg == ST_FRAME) && bit_stb && (nbits_reg != `RGW_LEN_WRITE)) begin
        shift_reg <= {shift_reg[36:0], bit_val};
        nbits_reg <= nbits_reg + 6'h01;
      end
      // Program fields hold the last accepted frame until the next one.
      if (ev_prog) begin
        pstb_reg   <= 1'b1;
        plock_reg  <= shift_reg[35];
        pdata_reg  <= shift_reg[34:3];
        pblock_reg <= shift_reg[2:0];
      end
      if (ev_wake) begin
        ireset_reg  <= 1'b1;
        awake_reg   <= 1'b1;
        stopped_reg <= 1'b0;
      end
      if (ev_stop) begin
        stopped_reg <= 1'b1;
      end
      // Modulation pauses during a frame, so the reader's gaps are not disturbed.
      mod_out_reg <= awake_reg && !stopped_reg && (state_next == ST_IDLE) && !ev_wake;
    end
  end

  // ----------------------------------------------------------------------
  // Registers and interrupt
  // ----------------------------------------------------------------------
  assign events = {ev_err, ev_stop, ev_wake, ev_prog};

  always @(posedge mclk) begin
    if (rst) begin
      ctrl_wake_reg <= `RGW_RST_WAKE;
      ctrl_mod_reg  <= `RGW_RST_MOD;
      ctrl_rate_reg <= `RGW_RST_RATE;
      ctrl_blk_reg  <= `RGW_RST_BLK;
      password_reg  <= `RGW_RST_PASSWORD;
      status_reg    <= 4'h0;
      mask_reg      <= 4'h0;
      rdata_reg     <= 32'h0000_0000;
    end else begin
      if (reg_wr && (reg_addr == `RGW_OFS_CTRL)) begin
        ctrl_wake_reg <= reg_wdata[`RGW_CTRL_WAKE_BIT];
        ctrl_mod_reg  <= reg_wdata[`RGW_CTRL_MOD_LSB +: 3];
        ctrl_rate_reg <= reg_wdata[`RGW_CTRL_RATE_LSB +: 3];
        ctrl_blk_reg  <= reg_wdata[`RGW_CTRL_BLK_LSB +: 3];
      end
      if (reg_wr && (reg_addr == `RGW_OFS_PASSWORD)) begin
        password_reg <= reg_wdata;
      end
      if (reg_wr && (reg_addr == `RGW_OFS_MASK)) begin
        mask_reg <= reg_wdata[3:0];
      end
      // A new event wins over a write-one clear in the same cycle.
      if (reg_wr && (reg_addr == `RGW_OFS_STATUS)) begin
        status_reg <= (status_reg & ~reg_wdata[3:0]) | events;
      end else begin
        status_reg <= status_reg | events;
      end
      // Read data is zero outside the answer cycle, so several blocks may
      // share one read bus by a plain OR.
      rdata_reg <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `RGW_OFS_CTRL:      rdata_reg <= {22'h0, ctrl_blk_reg, ctrl_rate_reg,
                                            ctrl_mod_reg, ctrl_wake_reg};
          `RGW_OFS_PASSWORD:  rdata_reg <= password_reg;
          `RGW_OFS_STATUS:    rdata_reg <= {28'h0, status_reg};
          `RGW_OFS_MASK:      rdata_reg <= {28'h0, mask_reg};
          `RGW_OFS_PROG_DATA: rdata_reg <= pdata_reg;
          `RGW_OFS_PROG_INFO: rdata_reg <= {24'h0, state_reg, stopped_reg, awake_reg,
                                            plock_reg, pblock_reg};
          default:            rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign reg_rdata          = rdata_reg;
  // The interrupt is a level, so it stays high until software clears the cause.
  assign irq                = |(status_reg & mask_reg);
  assign modulate_en        = mod_out_reg;
  assign internal_reset     = ireset_reg;
  assign prog_stb           = pstb_reg;
  assign prog_lock          = plock_reg;
  assign prog_data          = pdata_reg;
  assign prog_block         = pblock_reg;
  assign mod_type           = ctrl_mod_reg;
  assign rate_div           = rate_of(ctrl_rate_reg);
  assign last_readout_block = ctrl_blk_reg;

endmodule // rgw_gap_decoder

// >>> testbench/rgw_gap_decoder_chk.sv
// Assertions on the gap write decoder ports.
// Assumes binding to rgw_gap_decoder; sees its ports only.
`timescale 1ns/1ps

module rgw_gap_decoder_chk (
  input wire        mclk,
  input wire        rst,
  input wire        coil_low_in,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        irq,
  input wire        modulate_en,
  input wire        internal_reset,
  input wire        prog_stb,
  input wire        prog_lock,
  input wire [31:0] prog_data,
  input wire [2:0]  prog_block,
  input wire [2:0]  mod_type,
  input wire [7:0]  rate_div,
  input wire [2:0]  last_readout_block
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_prog_pulse;
    prog_stb |=> !prog_stb;
  endproperty
  a_prog_pulse: assert property (p_prog_pulse) else $error("prog_stb too long");
  property p_prog_hold;
    !prog_stb |-> $stable({prog_lock, prog_data, prog_block});
  endproperty
  a_prog_hold: assert property (p_prog_hold) else $error("prog fields moved");
  property p_prog_mod;
    prog_stb |-> ##[0:2] modulate_en;
  endproperty
  a_prog_mod: assert property (p_prog_mod) else $error("no read mode");
  property p_wake_pulse;
    internal_reset |=> !internal_reset;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("reset pulse long");
  property p_wake_mod;
    internal_reset |-> ##[1:2] modulate_en;
  endproperty
  a_wake_mod: assert property (p_wake_mod) else $error("no modulation");
  property p_cfg_reset;
    $fell(rst) |-> mod_type == 3'h3 && rate_div == 8'h20
      && last_readout_block == 3'h2 && !irq && !modulate_en;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("bad reset config");
  property p_rate_legal;
    rate_div inside {8'h08, 8'h10, 8'h20, 8'h28, 8'h32, 8'h40, 8'h64, 8'h80};
  endproperty
  a_rate_legal: assert property (p_rate_legal) else $error("bad rate");
  property p_gap_quiet;
    $rose(coil_low_in) |-> ##[1:10] !modulate_en;
  endproperty
  a_gap_quiet: assert property (p_gap_quiet) else $error("gap missed");
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");

  c_prog: cover property (prog_stb);
  c_wake: cover property (internal_reset);
  c_irq: cover property ($rose(irq));
endmodule // rgw_gap_decoder_chk

bind rgw_gap_decoder rgw_gap_decoder_chk u_chk (
  .mclk, .rst, .coil_low_in, .reg_rd, .reg_rdata, .irq, .modulate_en,
  .internal_reset, .prog_stb, .prog_lock, .prog_data, .prog_block,
  .mod_type, .rate_div, .last_readout_block
);

// >>> testbench/rgw_reader_model.sv
// Reader base station: gaps the field to send frames.
// Assumes a field clock far slower than mclk; counts are compressed in time.
`timescale 1ns/1ps

module rgw_reader_model (
  output logic field_clk,
  output logic coil_low
);
  localparam int HALF = 40;

  initial begin
    field_clk = 1'b0;
    coil_low  = 1'b0;
  end
  task automatic pulses(input int n);
    repeat (n) begin
      #HALF field_clk = 1'b1;
      #HALF field_clk = 1'b0;
    end
  endtask
  task automatic gap();
    #HALF coil_low = 1'b1;
    #(6 * HALF) coil_low = 1'b0;
  endtask
  task automatic frame(input logic [37:0] b, input int n, input int c0, input int c1);
    int i;
    #3;
    gap();
    for (i = n - 1; i >= 0; i--) begin
      pulses(b[i] ? c1 : c0);
      gap();
    end
    pulses(70);
  endtask
endmodule // rgw_reader_model

// >>> testbench/tb_rf_gap_write_decode_and_wake.sv
// Testbench for the gap write decoder: bus tasks, scenarios, verdict.
// Assumes the reader model drives the field pins.
`timescale 1ns/1ps

module tb_rf_gap_write_decode_and_wake;
  localparam logic [31:0] PW = 32'h5A3C_96E1;
  logic        mclk, rst, reg_wr, reg_rd;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  wire         field_clk, coil_low, irq, modulate_en, internal_reset, prog_stb, prog_lock;
  wire  [31:0] reg_rdata, prog_data;
  wire  [2:0]  prog_block, mod_type, last_readout_block;
  wire  [7:0]  rate_div;
  int          err_count, compares, n_prog, n_wake;

  rgw_reader_model rdr (.field_clk(field_clk), .coil_low(coil_low));
  rgw_gap_decoder uut (
    .mclk, .rst, .field_clk_in(field_clk), .coil_low_in(coil_low), .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .modulate_en, .internal_reset,
    .prog_stb, .prog_lock, .prog_data, .prog_block, .mod_type, .rate_div,
    .last_readout_block
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (prog_stb === 1'b1) n_prog <= n_prog + 1;
    if (internal_reset === 1'b1) n_wake <= n_wake + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic send(input logic [37:0] b, input int n, input int c0, input int c1);
    rdr.frame(b, n, c0, c1);
    repeat (5) @(posedge mclk);
    #1;
  endtask
  task automatic power_up();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic t_reset();
    rd(4'h0, 32'h126);
    rd(4'h1, 32'h0);
    rd(4'hF, 32'h0);
    chk({21'h0, last_readout_block, rate_div}, {21'h0, 3'h2, 8'h20});
    chk({29'h0, mod_type}, 32'h3);
    chk({31'h0, modulate_en}, 32'h1);
  endtask
  task automatic t_rates();
    logic [7:0] tbl [8] = '{8'h08, 8'h10, 8'h20, 8'h28, 8'h32, 8'h40, 8'h64, 8'h80};
    int i;
    for (i = 0; i < 8; i++) begin
      wr(4'h0, (i << 7) | (i << 4) | ((i % 5) << 1));
      @(posedge mclk);
      #1 chk({24'h0, rate_div}, {24'h0, tbl[i]});
      chk({29'h0, mod_type}, i % 5);
      chk({29'h0, last_readout_block}, i);
    end
    wr(4'h0, 32'h126);
  endtask
  task automatic t_write(input logic lk, input logic [31:0] d, input logic [2:0] b,
                         input int c0, input int c1);
    int n0;
    n0 = n_prog;
    send({2'b10, lk, d, b}, 38, c0, c1);
    chk(n_prog - n0, 1);
    chk(prog_data, d);
    chk({28'h0, prog_lock, prog_block}, {28'h0, lk, b});
    chk({30'h0, irq, modulate_en}, 32'h3);
    wr(4'h2, 32'h1);
    rd(4'h2, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_err();
    int bad [3] = '{15, 33, 47};
    int i, n0;
    n0 = n_prog;
    for (i = 0; i < 4; i++) begin
      wr(4'h3, i == 3 ? 32'h0 : 32'hF);
      if (i < 3) send(38'h1, 2, 24, bad[i]);
      else send(38'h2, 2, 24, 56);
      rd(4'h2, 32'h8);
      chk({30'h0, irq, modulate_en}, {30'h0, i < 3, 1'b1});
      wr(4'h2, 32'hF);
    end
    chk(n_prog - n0, 0);
    wr(4'h3, 32'hF);
  endtask
  task automatic t_wake();
    int n0;
    wr(4'h1, PW);
    rd(4'h1, PW);
    send(38'h3, 2, 24, 56);
    chk({31'h0, modulate_en}, 32'h0);
    rd(4'h2, 32'h4);
    n0 = n_wake;
    send({4'h1, PW ^ 32'h1}, 34, 16, 48);
    chk(n_wake - n0, 0);
    chk({31'h0, modulate_en}, 32'h0);
    wr(4'h2, 32'hF);
    send({4'h1, PW}, 34, 16, 48);
    chk(n_wake - n0, 1);
    chk({31'h0, modulate_en}, 32'h1);
    rd(4'h2, 32'h2);
    wr(4'h2, 32'hF);
    send(38'h3, 2, 32, 64);
    chk({31'h0, modulate_en}, 32'h0);
    rd(4'h2, 32'h4);
    power_up();
    chk({31'h0, modulate_en}, 32'h1);
    rd(4'h2, 32'h0);
  endtask

  task automatic finish_test();
    $display("Checks: %0d, errors: %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #1_000_000;
    err_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    finish_test();
  end
  initial begin
    rst       = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 32'h0;
    power_up();
    t_reset();
    wr(4'h3, 32'hF);
    t_rates();
    t_write(1'b1, 32'hA5C3_0F96, 3'h5, 16, 64);
    t_write(1'b0, 32'h3C5A_E187, 3'h2, 32, 48);
    t_err();
    t_wake();
    finish_test();
  end
endmodule // tb_rf_gap_write_decode_and_wake
